// ===== logic/fsvs_consts.svh
`ifndef FSVS_CONSTS_SVH
`define FSVS_CONSTS_SVH
// Time base: 40 MHz clock, one tick per millisecond.
`define FSVS_CLK_HZ        40000000
`define FSVS_TICK_US       1000
`define FSVS_TICK_CYC      ((`FSVS_CLK_HZ / 1000000) * `FSVS_TICK_US)
// Worst case vector surge decision latency, in ms.
`define FSVS_SURGE_MAX_MS  60
// Dropout ratio: release below trip * 9995 / 10000.
`define FSVS_DROP_NUM      32'd9995
`define FSVS_DROP_DEN      32'd10000
// Absolute dropout margin: 0.05 % of nominal = nominal * 5 / 10000.
`define FSVS_MARGIN_NUM    32'd5
`define FSVS_FREQ_W        20
`define FSVS_PER_W         24
`define FSVS_WIN_W         16
`define FSVS_PRE_W         16
`define FSVS_PHASES        3
`endif

// ===== logic/fsvs_pkg.sv
`include "fsvs_consts.svh"
package fsvs_pkg;
    // ========================================================================
    // Types
    // Operating modes of the frequency element.
    typedef enum logic [1:0] {
        FSVS_MODE_UNDER = 2'h0,
        FSVS_MODE_OVER  = 2'h1,
        FSVS_MODE_SURGE = 2'h3
    } fsvs_mode_t;

    // Difference-mode sequencer states, Gray coded along the path.
    typedef enum logic [1:0] {
        FSVS_ST_IDLE  = 2'h0,
        FSVS_ST_WATCH = 2'h1,
        FSVS_ST_TRIP  = 2'h3,
        FSVS_ST_LOCK  = 2'h2
    } fsvs_state_t;

    // Per-phase measurement from the front end.
    typedef struct packed {
        logic [`FSVS_FREQ_W-1:0] freq;       // Frequency, fixed point.
        logic                    zero_cross; // One-cycle zero crossing pulse.
        logic                    volt_ok;    // Above minimum voltage.
        logic                    present;    // Phase not lost.
    } fsvs_phase_t;

    // Settings of the active parameter set.
    typedef struct packed {
        fsvs_mode_t              mode;
        logic [`FSVS_FREQ_W-1:0] pickup_freq;
        logic [`FSVS_FREQ_W-1:0] freq_change_limit;
        logic [`FSVS_WIN_W-1:0]  supervision_window; // In ticks.
        logic [`FSVS_FREQ_W-1:0] nominal_freq;
        logic [`FSVS_PER_W-1:0]  ref_period;        // In clock cycles.
        logic [`FSVS_PER_W-1:0]  surge_limit;       // Period deviation.
        logic [1:0]              surge_phase_count; // 1, 2 or 3.
    } fsvs_cfg_t;

    // Per-phase period measurement result.
    typedef struct packed {
        logic                   done;   // One-cycle pulse on each crossing after the first.
        logic [`FSVS_PER_W-1:0] dev;    // Absolute period deviation.
    } fsvs_per_t;
endpackage : fsvs_pkg

// ===== logic/fsvs_period_meter.sv
`include "fsvs_consts.svh"
// Measures one voltage period between zero crossings and its deviation.
module fsvs_period_meter
    import fsvs_pkg::*;
(
    // Clock and reset.
    input  wire logic                   core_clk_i,
    input  wire logic                   reset_n_i,
    // Measurement.
    input  wire logic                   zero_cross_i,
    input  wire logic [`FSVS_PER_W-1:0] ref_period_i,
    output fsvs_per_t                   result_o
);
    // ========================================================================
    // State
    typedef struct packed {
        logic [`FSVS_PER_W-1:0] cnt;   // Cycles since last crossing.
        logic                   armed; // A first crossing has been seen.
        fsvs_per_t              res;
    } fsvs_pm_state_t;

    fsvs_pm_state_t st_r;  // Registered state.
    fsvs_pm_state_t st_nxt; // Next state.

    // Restarts the count at each crossing and compares with the reference.
    always_comb begin
        st_nxt          = st_r;
        st_nxt.res.done = 1'b0;
        if (st_r.cnt != {`FSVS_PER_W{1'b1}}) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
        if (zero_cross_i) begin
            // The crossing cycle is already the first one of the new
            // period, so a period equal to the reference reads as zero.
            st_nxt.cnt   = `FSVS_PER_W'(1);
            st_nxt.armed = 1'b1;
            // The first crossing has no full period behind it.
            if (st_r.armed) begin
                st_nxt.res.done = 1'b1;
                st_nxt.res.dev  = (st_r.cnt > ref_period_i) ?
                    st_r.cnt - ref_period_i :
                    ref_period_i - st_r.cnt;
            end
        end
    end

    // Registers the state.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign result_o = st_r.res;

    chk_period_restart: assert property (@(posedge core_clk_i)
        disable iff (!reset_n_i) zero_cross_i |=>
        st_r.cnt == `FSVS_PER_W'(1))
        else $error("Period count not restarted at crossing.");
endmodule : fsvs_period_meter

// ===== logic/fsvs_trip.sv
`include "fsvs_consts.svh"
// Function
// - Block evaluation when all three voltages low
// - Mode selects under, over or vector surge
// - Set holds pickup, change limit, window
// - Alarm at pickup crossing unless blocked
// - Window timer starts with the alarm
// - Trip if change reached inside window
// - Window expiry: no trip, lock until recrossing
// - Period measurement restarts at each crossing
// - Period deviation against reference is surge angle
// - Surge alarm and trip together in N phases
// - Phase loss suppresses surge trip
// - Voltage lockout precedes surge decision
// - Surge detected within 60 ms
// - Overfrequency releases only below dropout level
module fsvs_trip
    import fsvs_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    // Measurement and settings.
    input  fsvs_phase_t      line_voltage_ab_i,
    input  fsvs_phase_t      line_voltage_bc_i,
    input  fsvs_phase_t      line_voltage_ca_i,
    input  fsvs_cfg_t        cfg_i,
    input  wire logic        block_i,
    // Indications.
    output logic             alarm_o,
    output logic             trip_o,
    output logic             locked_o,
    output logic             inhibit_o
);
    // ========================================================================
    // Phase handling
    fsvs_phase_t ph [`FSVS_PHASES];
    fsvs_per_t   per [`FSVS_PHASES];
    logic [`FSVS_PHASES-1:0] beyond;   // Frequency past pickup.
    logic [`FSVS_PHASES-1:0] released; // Past the dropout level.
    logic [`FSVS_PHASES-1:0] surge_hit;

    assign ph[0] = line_voltage_ab_i;
    assign ph[1] = line_voltage_bc_i;
    assign ph[2] = line_voltage_ca_i;

    // Dropout levels for the overfrequency element.
    logic [`FSVS_FREQ_W+13:0] drop_ratio;
    logic [`FSVS_FREQ_W+13:0] drop_margin;
    assign drop_ratio = (`FSVS_FREQ_W+14)'(cfg_i.pickup_freq * `FSVS_DROP_NUM
                        / `FSVS_DROP_DEN);
    assign drop_margin = (`FSVS_FREQ_W+14)'(cfg_i.pickup_freq -
        cfg_i.nominal_freq * `FSVS_MARGIN_NUM / `FSVS_DROP_DEN);

    genvar g;
    generate
        for (g = 0; g < `FSVS_PHASES; g++) begin : g_ph
            // Per-phase period meter.
            fsvs_period_meter u_pm (
                .core_clk_i  (core_clk_i),
                .reset_n_i   (reset_n_i),
                .zero_cross_i(ph[g].zero_cross),
                .ref_period_i(cfg_i.ref_period),
                .result_o    (per[g])
            );
            // Pickup comparison follows the selected mode.
            assign beyond[g] = (cfg_i.mode == FSVS_MODE_UNDER) ?
                (ph[g].freq < cfg_i.pickup_freq) :
                (ph[g].freq > cfg_i.pickup_freq);
            // Over mode releases once below either dropout level.
            assign released[g] = (cfg_i.mode == FSVS_MODE_UNDER) ?
                !beyond[g] :
                ((`FSVS_FREQ_W+14)'(ph[g].freq) < drop_ratio) ||
                ((`FSVS_FREQ_W+14)'(ph[g].freq) < drop_margin);
            assign surge_hit[g] = per[g].done && ph[g].volt_ok &&
                (per[g].dev > cfg_i.surge_limit);
        end
    endgenerate

    // ========================================================================
    // Combined conditions
    logic volt_low;   // All three voltages below minimum.
    logic phase_lost;
    logic any_beyond;
    logic all_released;
    logic [1:0] surge_n;
    assign volt_low = !(ph[0].volt_ok || ph[1].volt_ok || ph[2].volt_ok);
    assign phase_lost = !(ph[0].present && ph[1].present && ph[2].present);
    assign any_beyond = |beyond;
    assign all_released = &released;
    assign surge_n = 2'(surge_hit[0]) + 2'(surge_hit[1]) + 2'(surge_hit[2]);

    // Change from the latched frequency on the first phase past pickup.
    logic [`FSVS_FREQ_W-1:0] cur_freq;
    logic [`FSVS_FREQ_W-1:0] change;
    always_comb begin
        cur_freq = ph[0].freq;
        if (!beyond[0] && beyond[1]) begin
            cur_freq = ph[1].freq;
        end else if (!beyond[0] && !beyond[1]) begin
            cur_freq = ph[2].freq;
        end
    end

    // ========================================================================
    // State
    typedef struct packed {
        fsvs_state_t             st;
        logic [`FSVS_PRE_W-1:0]  pre;    // Prescaler to 1 ms ticks.
        logic [`FSVS_WIN_W-1:0]  win;    // Ticks elapsed in the window.
        logic [`FSVS_FREQ_W-1:0] latch;  // Frequency at pickup.
        logic                    alarm;
        logic                    trip;
        logic                    locked;
        logic                    inhibit;
    } fsvs_state_s_t;

    fsvs_state_s_t s_r;
    fsvs_state_s_t s_nxt;

    assign change = (cur_freq > s_r.latch) ? cur_freq - s_r.latch :
                    s_r.latch - cur_freq;

    logic tick;
    assign tick = (s_r.pre == `FSVS_PRE_W'(`FSVS_TICK_CYC - 1));

    // Sequencer for difference and surge modes.
    always_comb begin
        s_nxt         = s_r;
        s_nxt.inhibit = volt_low;
        s_nxt.pre     = tick ? '0 : s_r.pre + 1'b1;
        s_nxt.locked  = (s_r.st == FSVS_ST_LOCK);
        if (volt_low || block_i) begin
            // Lockout acts before any decision from the same samples.
            s_nxt.st    = FSVS_ST_IDLE;
            s_nxt.alarm = 1'b0;
            s_nxt.trip  = 1'b0;
            s_nxt.win   = '0;
        end else if (cfg_i.mode == FSVS_MODE_SURGE) begin
            s_nxt.st = FSVS_ST_IDLE;
            // Alarm and trip in one step, no delay.
            s_nxt.trip = !phase_lost && surge_n != 2'h0 &&
                surge_n >= cfg_i.surge_phase_count;
            s_nxt.alarm = s_nxt.trip;
        end else begin
            unique case (s_r.st)
                FSVS_ST_IDLE: begin
                    s_nxt.alarm = 1'b0;
                    s_nxt.trip  = 1'b0;
                    if (any_beyond) begin
                        s_nxt.st    = FSVS_ST_WATCH;
                        s_nxt.alarm = 1'b1;
                        s_nxt.win   = '0;
                        // Restart the prescaler so the window is exact.
                        s_nxt.pre   = '0;
                        s_nxt.latch = cur_freq;
                    end
                end
                FSVS_ST_WATCH: begin
                    if (tick) begin
                        s_nxt.win = s_r.win + 1'b1;
                    end
                    if (all_released) begin
                        s_nxt.st    = FSVS_ST_IDLE;
                        s_nxt.alarm = 1'b0;
                    end else if (any_beyond &&
                                 change >= cfg_i.freq_change_limit) begin
                        // Trip only while still beyond the pickup level.
                        s_nxt.st   = FSVS_ST_TRIP;
                        s_nxt.trip = 1'b1;
                    end else if (s_r.win >= cfg_i.supervision_window) begin
                        s_nxt.st    = FSVS_ST_LOCK;
                        s_nxt.alarm = 1'b0;
                    end
                end
                FSVS_ST_TRIP: begin
                    // Held until release past the dropout level.
                    if (all_released) begin
                        s_nxt.st    = FSVS_ST_IDLE;
                        s_nxt.alarm = 1'b0;
                        s_nxt.trip  = 1'b0;
                    end
                end
                FSVS_ST_LOCK: begin
                    // Rearms only once the frequency leaves and returns.
                    if (all_released) begin
                        s_nxt.st = FSVS_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Registers the state; reset clears timer and outputs.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign alarm_o   = s_r.alarm;
    assign trip_o    = s_r.trip;
    assign locked_o  = s_r.locked;
    assign inhibit_o = s_r.inhibit;

    // ========================================================================
    // Checks
    chk_low_volt_quiet: assert property (@(posedge core_clk_i)
        disable iff (!reset_n_i) volt_low |=> !trip_o && !alarm_o)
        else $error("Output while all voltages low.");
    chk_pickup_alarm: assert property (@(posedge core_clk_i)
        disable iff (!reset_n_i) s_r.st == FSVS_ST_IDLE && any_beyond &&
        !volt_low && !block_i && cfg_i.mode != FSVS_MODE_SURGE |=> alarm_o)
        else $error("No alarm on pickup.");
    chk_window_start: assert property (@(posedge core_clk_i)
        disable iff (!reset_n_i) $rose(s_r.st == FSVS_ST_WATCH) |->
        s_r.win == '0) else $error("Window did not start at zero.");
    chk_no_trip_lock: assert property (@(posedge core_clk_i)
        disable iff (!reset_n_i) s_r.st == FSVS_ST_LOCK |-> !trip_o)
        else $error("Trip while locked.");
    chk_surge_pair: assert property (@(posedge core_clk_i)
        disable iff (!reset_n_i) cfg_i.mode == FSVS_MODE_SURGE &&
        $past(cfg_i.mode) == FSVS_MODE_SURGE |-> alarm_o == trip_o)
        else $error("Surge alarm and trip differ.");
    chk_phase_loss: assert property (@(posedge core_clk_i)
        disable iff (!reset_n_i) cfg_i.mode == FSVS_MODE_SURGE &&
        phase_lost |=> !trip_o) else $error("Surge trip on phase loss.");
    // The surge decision follows the completed period by one cycle.
    chk_surge_fast: assert property (@(posedge core_clk_i)
        disable iff (!reset_n_i) cfg_i.mode == FSVS_MODE_SURGE &&
        !volt_low && !block_i && !phase_lost && surge_n != 2'h0 &&
        surge_n >= cfg_i.surge_phase_count |=> trip_o)
        else $error("Surge decision late.");
    chk_over_hold: assert property (@(posedge core_clk_i)
        disable iff (!reset_n_i) s_r.st == FSVS_ST_TRIP && !all_released &&
        !volt_low && !block_i && cfg_i.mode == FSVS_MODE_OVER |=> trip_o)
        else $error("Over trip released early.");
    chk_tick_period: assert property (@(posedge core_clk_i)
        disable iff (!reset_n_i) tick |=> s_r.pre == '0)
        else $error("Prescaler not wrapped.");
    cov_diff_trip: cover property (@(posedge core_clk_i)
        s_r.st == FSVS_ST_WATCH ##1 s_r.st == FSVS_ST_TRIP);
    cov_lock: cover property (@(posedge core_clk_i) s_r.st == FSVS_ST_LOCK);
    cov_surge: cover property (@(posedge core_clk_i)
        cfg_i.mode == FSVS_MODE_SURGE && trip_o);
endmodule : fsvs_trip

// ===== tb/fsvs_front_model.sv
`include "fsvs_consts.svh"
// Front end stand-in: frequency, voltage flags and zero crossings.
module fsvs_front_model
    import fsvs_pkg::*;
(
    // Clock and reset.
    input  wire logic                    core_clk_i,
    input  wire logic                    reset_n_i,
    // Stimulus from the bench.
    input  wire logic [`FSVS_FREQ_W-1:0] freq_i,
    input  wire logic [2:0]              volt_ok_i,
    input  wire logic [2:0]              present_i,
    input  wire logic                    run_i,
    input  wire logic [`FSVS_PER_W-1:0]  period_i,
    // Phases towards the block.
    output fsvs_phase_t                  ab_o,
    output fsvs_phase_t                  bc_o,
    output fsvs_phase_t                  ca_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================================
    // Crossing generator
    logic [`FSVS_PER_W-1:0] cnt_r; // Cycles left in the current period.
    logic                   zc_r;  // One-cycle crossing pulse.
    // Counts each period down; no crossings while stopped.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= '0;
            zc_r  <= 1'b0;
        end else if (run_i && cnt_r == '0) begin
            cnt_r <= period_i - 1'b1;
            zc_r  <= 1'b1;
        end else begin
            cnt_r <= run_i ? cnt_r - 1'b1 : '0;
            zc_r  <= 1'b0;
        end
    end
    // All phases share one crossing so phase counts coincide.
    assign ab_o = '{freq_i, zc_r, volt_ok_i[0], present_i[0]};
    assign bc_o = '{freq_i, zc_r, volt_ok_i[1], present_i[1]};
    assign ca_o = '{freq_i, zc_r, volt_ok_i[2], present_i[2]};
endmodule : fsvs_front_model

// ===== tb/fsvs_trip_tb_top.sv
`include "fsvs_consts.svh"
module fsvs_trip_tb_top import fsvs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================================
    // Signals
    logic                    core_clk_i, reset_n_i, block_i, run;
    logic [`FSVS_FREQ_W-1:0] freq;     // Frequency on all phases.
    logic [2:0]              volt_ok;  // Per-phase voltage above minimum.
    logic [2:0]              present;  // Per-phase not lost.
    logic [`FSVS_PER_W-1:0]  period;   // Period of the crossings.
    fsvs_phase_t             ab, bc, ca;
    fsvs_cfg_t               cfg;
    logic                    alarm_o, trip_o, locked_o, inhibit_o;
    int error_cnt, comparisons, cyc, trip_cnt, pair_bad, base;
    // ========================================================================
    // Instances
    fsvs_front_model i_fsvs_front_model (.core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i), .freq_i(freq), .volt_ok_i(volt_ok),
        .present_i(present), .run_i(run), .period_i(period),
        .ab_o(ab), .bc_o(bc), .ca_o(ca));
    fsvs_trip i_fsvs_trip (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .line_voltage_ab_i(ab), .line_voltage_bc_i(bc),
        .line_voltage_ca_i(ca), .cfg_i(cfg), .block_i(block_i),
        .alarm_o(alarm_o), .trip_o(trip_o), .locked_o(locked_o),
        .inhibit_o(inhibit_o));
    // ========================================================================
    // Clock, trip monitor and timeout
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    // Counts cycles with trip high and surge cycles where alarm and trip disagree.
    // Samples on the falling edge, away from the edge that launches outputs.
    always @(negedge core_clk_i) begin
        cyc++;
        if (trip_o === 1'b1) trip_cnt++;
        if (cfg.mode == FSVS_MODE_SURGE && alarm_o !== trip_o) pair_bad++;
        if (cyc == 80000) begin
            error_cnt++;
            results();
        end
    end
    // ========================================================================
    // Helpers
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // Waits n edges, then samples once outputs have settled.
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : wt
    // Resets the block with the given mode and pickup.
    task automatic rst(input fsvs_mode_t m, input logic [19:0] pk);
        @(posedge core_clk_i);
        reset_n_i <= 1'b0;
        cfg.mode <= m;
        cfg.pickup_freq <= pk;
        freq <= 20'hC350;
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        wt(1);
        check("alarm_rst", alarm_o, 1'b0);
        check("trip_rst", trip_o, 1'b0);
        check("lock_rst", locked_o, 1'b0);
        check("inh_rst", inhibit_o, 1'b0);
        @(posedge core_clk_i);
    endtask : rst
    // Drives the frequency at the next edge.
    task automatic setf(input logic [19:0] f);
        @(posedge core_clk_i);
        freq <= f;
    endtask : setf
    // ========================================================================
    // Scenarios
    task automatic t_under();
        rst(FSVS_MODE_UNDER, 20'hBF68);
        freq <= 20'hBF04;
        wt(1);
        check("alarm", alarm_o, 1'b1);
        check("trip", trip_o, 1'b0);
        setf(20'hBB80);
        wt(2);
        check("trip", trip_o, 1'b1);
        setf(20'hC350);
        wt(3);
        check("alarm", alarm_o, 1'b0);
        $display("test under done");
    endtask : t_under
    task automatic t_block();
        rst(FSVS_MODE_UNDER, 20'hBF68);
        block_i <= 1'b1;
        freq <= 20'hBF04;
        wt(3);
        check("alarm_blk", alarm_o, 1'b0);
        @(posedge core_clk_i);
        block_i <= 1'b0;
        $display("test block done");
    endtask : t_block
    task automatic t_expiry();
        int n;
        rst(FSVS_MODE_UNDER, 20'hBF68);
        freq <= 20'hBF04;
        wt(1);
        check("alarm", alarm_o, 1'b1);
        for (n = 0; n < 40100 && locked_o !== 1'b1; n++) wt(1);
        check("locked", locked_o, 1'b1);
        // One tick of window, a cycle to decide, a cycle to register.
        check("win_len", n, `FSVS_TICK_CYC + 2);
        setf(20'hBB80);
        wt(3);
        check("trip_lock", trip_o, 1'b0);
        check("alarm_lock", alarm_o, 1'b0);
        setf(20'hC350);
        wt(2);
        setf(20'hBF04);
        wt(1);
        check("alarm_again", alarm_o, 1'b1);
        $display("test expiry done");
    endtask : t_expiry
    task automatic t_inhibit();
        rst(FSVS_MODE_UNDER, 20'hBF68);
        volt_ok <= 3'h0;
        freq <= 20'hBF04;
        wt(2);
        check("inhibit", inhibit_o, 1'b1);
        check("alarm_inh", alarm_o, 1'b0);
        volt_ok <= 3'h4;
        wt(2);
        check("inhibit", inhibit_o, 1'b0);
        volt_ok <= 3'h7;
        $display("test inhibit done");
    endtask : t_inhibit
    task automatic t_over();
        rst(FSVS_MODE_OVER, 20'hC738);
        freq <= 20'hC79C;
        wt(1);
        check("alarm_over", alarm_o, 1'b1);
        setf(20'hCB20);
        wt(2);
        check("trip_over", trip_o, 1'b1);
        setf(20'hC72E);
        wt(3);
        check("alarm_hold", alarm_o, 1'b1);
        check("trip_hold", trip_o, 1'b1);
        setf(20'hC6D4);
        wt(3);
        check("alarm_drop", alarm_o, 1'b0);
        check("trip_drop", trip_o, 1'b0);
        $display("test over done");
    endtask : t_over
    task automatic t_surge();
        rst(FSVS_MODE_SURGE, 20'hBF68);
        run <= 1'b1;
        // Trips of the earlier difference-mode tests are not counted here.
        base = trip_cnt;
        wt(4000);
        check("steady", trip_cnt - base, 32'h0);
        period <= 24'h352;
        wt(3000);
        check("surge", trip_cnt > base, 1'b1);
        check("paired", pair_bad, 32'h0);
        period <= 24'h320;
        present <= 3'h5;
        wt(2000);
        base = trip_cnt;
        period <= 24'h352;
        wt(3000);
        check("lost", trip_cnt - base, 32'h0);
        period <= 24'h320;
        present <= 3'h7;
        volt_ok <= 3'h0;
        wt(2000);
        base = trip_cnt;
        period <= 24'h352;
        wt(3000);
        check("lowv", trip_cnt - base, 32'h0);
        run <= 1'b0;
        $display("test surge done");
    endtask : t_surge
    // ========================================================================
    // Verdict
    task automatic results();
        $display("Counts: %0d compared, %0d wrong", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    // Main sequence.
    initial begin
        reset_n_i = 1'b0;
        block_i = 1'b0;
        run = 1'b0;
        freq = 20'hC350;
        volt_ok = 3'h7;
        present = 3'h7;
        period = 24'h320;
        cfg = '{FSVS_MODE_UNDER, 20'hBF68, 20'h320, 16'h1, 20'hC350,
                24'h320, 24'h14, 2'h1};
        t_under();
        t_block();
        t_expiry();
        t_inhibit();
        t_over();
        t_surge();
        results();
    end
endmodule : fsvs_trip_tb_top
